// ===== shared/ists_pkg.sv
// Purpose: Shared constants of the instrument self-test sequencer.
// Assumes: One system clock at 250 MHz.
// Notes:   Timing counts are derived from the printed time and the period.
package ists_pkg;
    // Operator test numbers.
    localparam logic [3:0] TEST_CARD = 4'h1;
    localparam logic [3:0] TEST_LAMP = 4'h2;
    localparam logic [3:0] TEST_LCD = 4'h3;
    localparam logic [3:0] TEST_HANDLER = 4'h4;
    localparam logic [3:0] TEST_EEPROM = 4'h5;
    localparam logic [3:0] TEST_SCANNER = 4'h6;
    localparam logic [3:0] TEST_BIAS = 4'h7;
    // Timing.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned ONE_SEC_NS = 1000000000;
    localparam int unsigned ONE_SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;
    // Memory check defaults.
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam logic [DATA_W-1:0] WRITE_PATTERN = 8'ha5;
    localparam logic [ADDR_W-1:0] FIRST_ADDR = 16'h0000;
    localparam logic [ADDR_W-1:0] CARD_LAST_ADDR = 16'hffff;
    localparam logic [ADDR_W-1:0] EEPROM_LAST_ADDR = 16'h00ff;
    // Interface widths.
    localparam int unsigned HANDLER_OUTS = 16;
    localparam int unsigned LAMP_COUNT = 5;
    localparam int unsigned CHAN_W = 8;
    localparam int unsigned BIAS_RD_W = 16;
    localparam int unsigned BIAS_WR_W = 8;
endpackage

// ===== verilog/ists_tick.sv
// Purpose: Prescaler giving a one-cycle pulse once per interval.
// Assumes: run held high for the whole test.
// Notes:   Counter restarts when run falls, so every test starts aligned.
`timescale 1ns/1ns
module ists_tick #(
    parameter int unsigned CYCLES = 250000000
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Control.
    input wire logic run,
    output logic tick
);
    localparam int unsigned CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;
    logic [CW-1:0] cnt_reg;
    logic last_cnt;

    generate
        if (CYCLES < 2) begin : g_bad
            $error("ists_tick: CYCLES must be at least 2");
        end
    endgenerate

    assign last_cnt = (cnt_reg == CW'(CYCLES - 1));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= (!run || last_cnt) ? '0 : cnt_reg + 1'b1;
            tick <= run && last_cnt;
        end
    end
endmodule

// ===== verilog/ists_chg.sv
// Purpose: Captures an input word only when its state changes.
// Assumes: Inputs are synchronous to clk_sys.
// Notes:   The first compare after enable uses the last seen value.
`timescale 1ns/1ns
module ists_chg #(
    parameter int unsigned W = 8
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Sampled word.
    input wire logic enable,
    input wire logic [W-1:0] din,
    output logic [W-1:0] cap,
    output logic changed
);
    logic [W-1:0] prev_reg;
    logic differs;

    assign differs = (din != prev_reg);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_reg <= '0;
            cap <= '0;
            changed <= 1'b0;
        end else begin
            prev_reg <= din;
            changed <= enable && differs;
            if (enable && differs) begin
                cap <= din;
            end
        end
    end

    a_cap_on_change: assert property (@(posedge clk_sys) disable iff (!resetn)
        !changed |=> $stable(cap) || changed)
        else $error("capture moved without an input change");
endmodule

// ===== verilog/ists_top.sv
// Purpose: Self-test sequencer for memory, lamps, display and interfaces.
// Assumes: Memory ports answer each held request with a one-cycle ack.
// Notes:   Operator keys are one-cycle pulses synchronous to clk_sys.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: Operator number selects the self test.
// RQ2: Card test writes pattern at lowest, reads back.
// RQ3: Card check advances from low to high.
// RQ4: Card contents restored before moving on.
// RQ5: Start, end and current addresses shown.
// RQ6: Mismatch stops card test, keeps failing address.
// RQ7: All addresses good gives completion status.
// RQ8: End command aborts memory tests.
// RQ9: Five lamps toggle together each second.
// RQ10: LCD shows all, inverts each second.
// RQ11: Handler outputs asserted singly, one second each.
// RQ12: Handler sequence loops until end command.
// RQ13: EEPROM test writes pattern at lowest, verifies.
// RQ14: EEPROM check ascends, stops at first mismatch.
// RQ15: EEPROM contents left as before test.
// RQ16: Scanner step and done strobes alternate.
// RQ17: Scanner inputs sampled only on change.
// RQ18: Bias chip selects asserted alternately.
// RQ19: Bias address and data step upward.
// RQ20: Bias data inputs captured on change.
// RQ21: One second comes from parameterised prescaler.
// RQ22: Write pattern is a configurable constant.
module ists_top #(
    parameter int unsigned ONE_SEC_CYCLES = ists_pkg::ONE_SEC_CYCLES,
    parameter int unsigned ADDR_W = ists_pkg::ADDR_W,
    parameter int unsigned DATA_W = ists_pkg::DATA_W,
    parameter logic [DATA_W-1:0] PATTERN = ists_pkg::WRITE_PATTERN,
    parameter logic [ADDR_W-1:0] CARD_LAST = ists_pkg::CARD_LAST_ADDR,
    parameter logic [ADDR_W-1:0] EEPROM_LAST = ists_pkg::EEPROM_LAST_ADDR,
    parameter int unsigned HANDLER_N = ists_pkg::HANDLER_OUTS
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Operator keys.
    input wire logic [3:0] test_number_in,
    input wire logic test_number_load,
    input wire logic test_start,
    input wire logic test_end,
    // Status and address display.
    output logic test_busy,
    output logic test_passed,
    output logic test_failed,
    output logic [ADDR_W-1:0] first_test_address,
    output logic [ADDR_W-1:0] last_test_address,
    output logic [ADDR_W-1:0] current_test_address,
    // Memory card port.
    output logic card_req,
    output logic card_we,
    output logic [ADDR_W-1:0] card_addr,
    output logic [DATA_W-1:0] card_wdata,
    input wire logic [DATA_W-1:0] card_rdata,
    input wire logic card_ack,
    // Scanner EEPROM port.
    output logic eep_req,
    output logic eep_we,
    output logic [ADDR_W-1:0] eep_addr,
    output logic [DATA_W-1:0] eep_wdata,
    input wire logic [DATA_W-1:0] eep_rdata,
    input wire logic eep_ack,
    // Front panel.
    output logic remote_lamp,
    output logic listen_lamp,
    output logic talk_lamp,
    output logic service_request_lamp,
    output logic bias_lamp,
    output logic lcd_all_chars,
    output logic lcd_inverse,
    // Handler interface.
    output logic [HANDLER_N-1:0] handler_out_n,
    // Scanner interface.
    output logic index_out_n,
    output logic measure_done_out_n,
    input wire logic [ists_pkg::CHAN_W-1:0] channel_number_in,
    input wire logic channel_strobe_in_n,
    output logic [ists_pkg::CHAN_W:0] scanner_capture,
    output logic scanner_changed,
    // Bias current interface.
    output logic [1:0] bias_cs_n,
    output logic bias_addr_out,
    output logic [ists_pkg::BIAS_WR_W-1:0] bias_wdata,
    input wire logic [ists_pkg::BIAS_RD_W-1:0] bias_rdata_in,
    output logic [ists_pkg::BIAS_RD_W-1:0] bias_capture,
    output logic bias_changed
);
    localparam int unsigned SEQ_W = $clog2(HANDLER_N);
    localparam int unsigned STEP_W = ists_pkg::BIAS_WR_W + 1;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SAVE, ST_WRITE, ST_CHECK, ST_RESTORE, ST_LOOP, ST_DONE
    } ists_state_t;

    generate
        if (HANDLER_N < 2) begin : g_bad_hnd
            $error("ists_top: HANDLER_N must be at least 2");
        end
        if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_width
            $error("ists_top: memory widths must be positive");
        end
    endgenerate

    function automatic logic is_mem_test(input logic [3:0] num);
        return num == ists_pkg::TEST_CARD || num == ists_pkg::TEST_EEPROM;
    endfunction

    ists_state_t state_reg;
    logic [3:0] test_sel_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] last_reg;
    logic [DATA_W-1:0] orig_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic fail_pend_reg;
    logic abort_reg;
    logic pass_reg;
    logic fail_reg;
    logic phase_reg;
    logic [SEQ_W-1:0] seq_reg;
    logic [STEP_W-1:0] step_reg;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding.
    logic can_start;
    logic use_card;
    logic mem_ack;
    logic [DATA_W-1:0] mem_rdata;
    logic mem_req;
    logic mem_we;
    logic mismatch;
    logic at_last;
    logic looping;
    logic run_lamp, run_lcd, run_hnd, run_scan, run_bias;
    logic [HANDLER_N-1:0] hnd_onehot;

    assign can_start = (state_reg == ST_IDLE || state_reg == ST_DONE);
    assign use_card = (test_sel_reg == ists_pkg::TEST_CARD);
    assign mem_ack = use_card ? card_ack : eep_ack;
    assign mem_rdata = use_card ? card_rdata : eep_rdata;
    assign mem_req = (state_reg == ST_SAVE) || (state_reg == ST_WRITE) ||
                     (state_reg == ST_CHECK) || (state_reg == ST_RESTORE);
    assign mem_we = (state_reg == ST_WRITE) || (state_reg == ST_RESTORE);
    assign mismatch = (mem_rdata != PATTERN);
    assign at_last = (addr_reg == last_reg);
    assign looping = (state_reg == ST_LOOP);
    // RQ1: test number decode
    assign run_lamp = looping && test_sel_reg == ists_pkg::TEST_LAMP;
    assign run_lcd = looping && test_sel_reg == ists_pkg::TEST_LCD;
    assign run_hnd = looping && test_sel_reg == ists_pkg::TEST_HANDLER;
    assign run_scan = looping && test_sel_reg == ists_pkg::TEST_SCANNER;
    assign run_bias = looping && test_sel_reg == ists_pkg::TEST_BIAS;
    assign hnd_onehot = {{(HANDLER_N-1){1'b0}}, 1'b1} << seq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Memory ports share one engine; only the selected one is requested.
    assign card_req = mem_req && use_card;
    assign eep_req = mem_req && !use_card;
    assign card_we = mem_we;
    assign eep_we = mem_we;
    assign card_addr = addr_reg;
    assign eep_addr = addr_reg;
    assign card_wdata = wdata_reg;
    assign eep_wdata = wdata_reg;

    // RQ5: address display
    assign first_test_address = ists_pkg::FIRST_ADDR;
    assign last_test_address = last_reg;
    assign current_test_address = addr_reg;
    assign test_busy = !can_start;
    assign test_passed = pass_reg;
    assign test_failed = fail_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer. A request, once raised, is held until acked, so an end
    // command only takes effect at a safe point and never leaves the
    // pattern sitting in a location.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            test_sel_reg <= 4'h0;
            addr_reg <= '0;
            last_reg <= '0;
            orig_reg <= '0;
            wdata_reg <= '0;
            fail_pend_reg <= 1'b0;
            abort_reg <= 1'b0;
            pass_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            // RQ8: end command noted
            if (test_end && mem_req) begin
                abort_reg <= 1'b1;
            end
            unique case (state_reg)
                ST_IDLE, ST_DONE: begin
                    // RQ1: number entry
                    if (test_number_load) begin
                        test_sel_reg <= test_number_in;
                    end else if (test_start &&
                                 test_sel_reg >= ists_pkg::TEST_CARD &&
                                 test_sel_reg <= ists_pkg::TEST_BIAS) begin
                        pass_reg <= 1'b0;
                        fail_reg <= 1'b0;
                        fail_pend_reg <= 1'b0;
                        abort_reg <= 1'b0;
                        // RQ2: begin at lowest address
                        addr_reg <= ists_pkg::FIRST_ADDR;
                        last_reg <= use_card ? CARD_LAST : EEPROM_LAST;
                        state_reg <= is_mem_test(test_sel_reg) ? ST_SAVE
                                                               : ST_LOOP;
                    end else if (test_end) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SAVE: if (mem_ack) begin
                    orig_reg <= mem_rdata;
                    // RQ22: configurable pattern
                    wdata_reg <= PATTERN;
                    state_reg <= (abort_reg || test_end) ? ST_IDLE : ST_WRITE;
                end
                ST_WRITE: if (mem_ack) begin
                    state_reg <= ST_CHECK;
                end
                // RQ13: verify written pattern
                ST_CHECK: if (mem_ack) begin
                    fail_pend_reg <= mismatch;
                    wdata_reg <= orig_reg;
                    state_reg <= ST_RESTORE;
                end
                // RQ4: restore before advancing
                // RQ15: EEPROM contents kept
                ST_RESTORE: if (mem_ack) begin
                    if (fail_pend_reg) begin
                        // RQ6: stop and keep address
                        fail_reg <= 1'b1;
                        state_reg <= ST_DONE;
                    end else if (abort_reg || test_end) begin
                        state_reg <= ST_IDLE;
                    end else if (at_last) begin
                        // RQ7: completion status
                        pass_reg <= 1'b1;
                        state_reg <= ST_DONE;
                    end else begin
                        // RQ3: next address upward
                        // RQ14: EEPROM ascends too
                        addr_reg <= addr_reg + 1'b1;
                        state_reg <= ST_SAVE;
                    end
                end
                // RQ12: loop until end command
                ST_LOOP: if (test_end) begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Once-per-second stepping for the looping tests.
    // RQ21: parameterised prescaler
    ists_tick #(
        .CYCLES(ONE_SEC_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(looping),
        .tick(tick)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= 1'b0;
            seq_reg <= '0;
            step_reg <= '0;
        end else if (!looping) begin
            phase_reg <= 1'b0;
            seq_reg <= '0;
            step_reg <= '0;
        end else if (tick) begin
            phase_reg <= !phase_reg;
            // RQ11: next handler output
            seq_reg <= (seq_reg == SEQ_W'(HANDLER_N - 1)) ? '0
                                                          : seq_reg + 1'b1;
            // RQ19: ascending address and data
            step_reg <= step_reg + 1'b1;
        end
    end

    // RQ9: lamps toggle together
    assign remote_lamp = run_lamp && phase_reg;
    assign listen_lamp = run_lamp && phase_reg;
    assign talk_lamp = run_lamp && phase_reg;
    assign service_request_lamp = run_lamp && phase_reg;
    assign bias_lamp = run_lamp && phase_reg;
    // RQ10: all characters, inverse each second
    assign lcd_all_chars = (test_sel_reg == ists_pkg::TEST_LCD);
    assign lcd_inverse = run_lcd && phase_reg;
    // RQ11: one output at a time
    assign handler_out_n = run_hnd ? ~hnd_onehot : '1;
    // RQ16: step and done alternate
    assign index_out_n = !(run_scan && !phase_reg);
    assign measure_done_out_n = !(run_scan && phase_reg);
    // RQ18: chip selects alternate
    assign bias_cs_n = {!(run_bias && phase_reg), !(run_bias && !phase_reg)};
    assign bias_addr_out = run_bias && step_reg[STEP_W-1];
    assign bias_wdata = run_bias ? step_reg[STEP_W-2:0] : '0;

    ////////////////////////////////////////////////////////////////////////////
    // Input capture on change.
    // RQ17: scanner inputs on change
    ists_chg #(
        .W(ists_pkg::CHAN_W + 1)
    ) u_scan_chg (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(run_scan),
        .din({channel_strobe_in_n, channel_number_in}),
        .cap(scanner_capture),
        .changed(scanner_changed)
    );

    // RQ20: bias inputs on change
    ists_chg #(
        .W(ists_pkg::BIAS_RD_W)
    ) u_bias_chg (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(run_bias),
        .din(bias_rdata_in),
        .cap(bias_capture),
        .changed(bias_changed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_start_lowest: assert property ( // RQ2
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == ST_SAVE && $past(can_start) |-> addr_reg == '0)
        else $error("memory test did not start at lowest address");

    a_pattern_write: assert property ( // RQ22
        @(posedge clk_sys) disable iff (!resetn)
        card_req && card_we && state_reg == ST_WRITE |-> card_wdata == PATTERN)
        else $error("card write does not carry the pattern");

    a_addr_ascends: assert property ( // RQ3
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == ST_RESTORE && mem_ack && !fail_pend_reg && !abort_reg
        && !test_end && !at_last |=> addr_reg == $past(addr_reg) + 1'b1)
        else $error("test address did not step up by one");

    a_restore_orig: assert property ( // RQ4
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == ST_RESTORE |-> wdata_reg == orig_reg)
        else $error("restore write differs from saved data");

    a_fail_holds: assert property ( // RQ6
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == ST_CHECK && mem_ack && mismatch |=>
        state_reg == ST_RESTORE && $stable(addr_reg))
        else $error("mismatch did not freeze the address");

    a_pass_last: assert property ( // RQ7
        @(posedge clk_sys) disable iff (!resetn)
        $rose(pass_reg) |-> !fail_reg && addr_reg == last_reg)
        else $error("pass raised before the last address");

    a_end_stops: assert property ( // RQ12
        @(posedge clk_sys) disable iff (!resetn)
        looping && test_end |=> state_reg == ST_IDLE && handler_out_n == '1)
        else $error("end command did not stop a looping test");

    a_lamp_toggle: assert property ( // RQ9
        @(posedge clk_sys) disable iff (!resetn)
        run_lamp && tick && !test_end |=> remote_lamp != $past(remote_lamp))
        else $error("lamps did not toggle on the second");

    a_handler_single: assert property ( // RQ11
        @(posedge clk_sys) disable iff (!resetn)
        run_hnd |-> $onehot(~handler_out_n))
        else $error("handler outputs not asserted one at a time");

    a_strobes_alt: assert property ( // RQ16
        @(posedge clk_sys) disable iff (!resetn)
        run_scan |-> index_out_n != measure_done_out_n)
        else $error("scanner strobes not alternating");
endmodule

// ===== verif/ists_mem_model.sv
// Purpose: Memory card or EEPROM answering the sequencer's memory port.
// Assumes: One access per held request, acked lat cycles after it is seen.
// Notes:   A stuck cell ignores writes so a failing location can be made.
`timescale 1ns/1ns
module ists_mem_model #(
    parameter int unsigned N = 16
) (
    // Clock.
    input wire logic clk_sys,
    // Access.
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic ack,
    // Behaviour.
    input wire logic [3:0] lat,
    input wire logic stuck_en,
    input wire logic [15:0] stuck_addr
);
    logic [7:0] mem [N];
    int cnt = 0;
    initial begin
        ack = 1'b0;
        rdata = 8'h00;
        for (int i = 0; i < N; i++) begin
            mem[i] = 8'(i * 3 + 1);
        end
    end
    // Read data is only good with ack, so it keeps moving in between.
    always @(posedge clk_sys) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack) begin
            if (cnt >= lat) begin
                cnt <= 0;
                ack <= 1'b1;
                if (!we) begin
                    rdata <= mem[addr];
                end else if (!(stuck_en && addr == stuck_addr)) begin
                    mem[addr] <= wdata;
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// ===== verif/tb_top.sv
// Purpose: Self-checking bench of the self-test sequencer.
// Assumes: Short second of 8 cycles and small address ranges.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned ONE = 8;
    localparam logic [15:0] CL = 16'h0007;
    localparam logic [15:0] EL = 16'h0003;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] num = 4'h0;
    logic load = 1'b0, start = 1'b0, stop = 1'b0;
    logic busy, pass, fail, creq, cwe, ereq, ewe, cack, eack, lall;
    logic [15:0] fa, la, ca, caddr, eaddr, hnd, bcap;
    logic [7:0] cwd, crd, ewd, erd, bwd;
    logic [4:0] lamp;
    logic linv, idx_n, done_n, schg, baddr, bchg;
    logic [7:0] chan = 8'h00;
    logic strb_n = 1'b1;
    logic [15:0] brd = 16'h0000;
    logic [8:0] scap;
    logic [1:0] cs_n;
    logic [3:0] lat = 4'h0;
    logic stk = 1'b0;
    int err_total = 0, checked = 0, acc = 0;
    wire [34:0] obs = {lamp, linv, idx_n, done_n, cs_n, baddr, bwd, hnd};

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    ists_top #(.ONE_SEC_CYCLES(ONE), .CARD_LAST(CL), .EEPROM_LAST(EL)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .test_number_in(num),
        .test_number_load(load), .test_start(start), .test_end(stop),
        .test_busy(busy), .test_passed(pass), .test_failed(fail),
        .first_test_address(fa), .last_test_address(la),
        .current_test_address(ca), .card_req(creq), .card_we(cwe),
        .card_addr(caddr), .card_wdata(cwd), .card_rdata(crd),
        .card_ack(cack), .eep_req(ereq), .eep_we(ewe), .eep_addr(eaddr),
        .eep_wdata(ewd), .eep_rdata(erd), .eep_ack(eack),
        .remote_lamp(lamp[4]), .listen_lamp(lamp[3]), .talk_lamp(lamp[2]),
        .service_request_lamp(lamp[1]), .bias_lamp(lamp[0]),
        .lcd_all_chars(lall), .lcd_inverse(linv), .handler_out_n(hnd),
        .index_out_n(idx_n), .measure_done_out_n(done_n),
        .channel_number_in(chan), .channel_strobe_in_n(strb_n),
        .scanner_capture(scap), .scanner_changed(schg),
        .bias_cs_n(cs_n), .bias_addr_out(baddr), .bias_wdata(bwd),
        .bias_rdata_in(brd), .bias_capture(bcap), .bias_changed(bchg));
    ists_mem_model u_card (.clk_sys(clk_sys), .req(creq), .we(cwe),
        .addr(caddr), .wdata(cwd), .rdata(crd), .ack(cack), .lat(lat),
        .stuck_en(stk), .stuck_addr(16'h0003));
    ists_mem_model u_eep (.clk_sys(clk_sys), .req(ereq), .we(ewe),
        .addr(eaddr), .wdata(ewd), .rdata(erd), .ack(eack), .lat(lat),
        .stuck_en(1'b0), .stuck_addr(16'h0000));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Accesses come in fours per address: save, pattern, check, restore.
    always @(posedge clk_sys) begin
        if ((creq && cack) || (ereq && eack)) begin
            check(creq ? caddr : eaddr, 32'(acc / 4));
            if (acc % 4 == 1) check(creq ? cwd : ewd, ists_pkg::WRITE_PATTERN);
            acc++;
        end
    end

    task automatic launch(input logic [3:0] n);
        acc = 0;
        @(negedge clk_sys);
        num = n;
        load = 1'b1;
        @(negedge clk_sys);
        load = 1'b0;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
    endtask

    task automatic finish_key;
        @(negedge clk_sys);
        stop = 1'b1;
        @(negedge clk_sys);
        stop = 1'b0;
    endtask

    task automatic wait_idle;
        int k = 0;
        while (busy !== 1'b0) begin
            @(negedge clk_sys);
            k++;
            if (k > 5000) begin
                err_total++;
                stop_test();
            end
        end
    endtask

    task automatic mem_ok(input logic [3:0] n, input logic [15:0] last);
        for (int i = 0; i <= last; i++) begin
            check(n == 1 ? u_card.mem[i] : u_eep.mem[i], 8'(i * 3 + 1));
        end
    endtask

    task automatic mem_run(input logic [3:0] n, input logic [15:0] last,
            input int nacc, input logic [1:0] st);
        launch(n);
        check(busy, 1'b1);
        wait_idle();
        check({pass, fail}, st);
        check(acc, nacc);
        check({fa, la}, {16'h0000, last});
        mem_ok(n, last);
    endtask

    task automatic loop_test(input logic [3:0] n);
        logic [34:0] p;
        int k;
        launch(n);
        p = obs;
        for (int r = 0; r < 18; r++) begin
            k = 0;
            while (obs === p && k < 40) begin
                @(negedge clk_sys);
                k++;
            end
            if (r > 0) begin
                check(k, ONE);
                case (n)
                    4'h2: check(obs[34:30], {5{~p[30]}});
                    4'h3: check({lall, obs[29]}, {1'b1, ~p[29]});
                    4'h4: check(obs[15:0], {p[14:0], p[15]});
                    4'h6: check(obs[28:27], {p[27], p[28]});
                    default: check(obs[26:16], {p[25], p[26], 9'(p[24:16] + 1)});
                endcase
                if (n == 4'h4) check($countones(obs[15:0]), 15);
            end
            p = obs;
        end
        for (int r = 0; r < 4 && n > 4'h5; r++) begin
            chan = 8'($urandom);
            strb_n = 1'($urandom);
            brd = 16'($urandom);
            repeat (3) @(negedge clk_sys);
            if (n == 4'h6) check(scap, {strb_n, chan});
            else check(bcap, brd);
        end
        finish_key();
        check(obs[34:16], {5'h00, 3'b011, 2'b11, 9'h000});
        check(obs[15:0], 16'hffff);
    endtask

    initial begin
        void'($urandom(32'h18f9));
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        launch(4'h0);
        check(busy, 1'b0);
        mem_run(ists_pkg::TEST_CARD, CL, 32, 2'b10);
        lat = 4'h2;
        mem_run(ists_pkg::TEST_EEPROM, EL, 16, 2'b10);
        stk = 1'b1;
        lat = 4'h1;
        mem_run(ists_pkg::TEST_CARD, CL, 16, 2'b01);
        check(ca, 16'h0003);
        stk = 1'b0;
        lat = 4'h3;
        launch(ists_pkg::TEST_CARD);
        repeat (30) @(negedge clk_sys);
        finish_key();
        wait_idle();
        check({pass, fail}, 2'b00);
        mem_ok(4'h1, CL);
        loop_test(ists_pkg::TEST_LAMP);
        loop_test(ists_pkg::TEST_LCD);
        loop_test(ists_pkg::TEST_HANDLER);
        loop_test(ists_pkg::TEST_SCANNER);
        loop_test(ists_pkg::TEST_BIAS);
        stop_test();
    end
endmodule
